//--- testbench/imb_chk.sv
// Checker for the serial wires, wake and device drive between the two ends.
// Assumes it sits beside the interface that joins the host and device instances.
`timescale 1ns/1ps
`default_nettype none

`include "imb_cfg.svh"

module imb_chk #(
  parameter int unsigned WAKE_LEAD_CYC = `IMB_WAKE_LEAD_CYC,
  parameter int unsigned WAKE_REL_CYC  = `IMB_WAKE_REL_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Interface wires
  input  wire logic scl_host_oe,
  input  wire logic sda_host_oe,
  input  wire logic sda_dev_oe,
  input  wire logic wake_request_n,
  input  wire logic irq_out_n,
  input  wire logic scl,
  input  wire logic sda
);
  logic        scl_q, sda_q, busy_q, ack_q, rw_q, first_q, addr_ok_q;
  logic [3:0]  bitc_q;
  logic [7:0]  shf_q;
  logic [15:0] lo_cnt_q, hi_cnt_q;
  logic        scl_rise, scl_fall, start_c, stop_c, slot9;

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_c  = scl & scl_q & sda_q & ~sda;
  assign stop_c   = scl & scl_q & ~sda_q & sda;
  assign slot9    = scl_rise & (bitc_q == 4'h8);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      busy_q <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      busy_q <= start_c | (busy_q & ~stop_c);
      ack_q  <= slot9 | (ack_q & ~scl_fall);
    end
  end

  // Bit and byte position inside a frame
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bitc_q    <= 4'h0;
      first_q   <= 1'b0;
      rw_q      <= 1'b0;
      addr_ok_q <= 1'b0;
      shf_q     <= 8'h00;
    end else if (start_c) begin
      bitc_q  <= 4'h0;
      first_q <= 1'b1;
    end else if (slot9) begin
      bitc_q  <= 4'h0;
      first_q <= 1'b0;
      if (first_q) begin
        rw_q      <= shf_q[0];
        addr_ok_q <= ~sda;
      end
    end else if (scl_rise) begin
      bitc_q <= bitc_q + 4'h1;
      shf_q  <= {shf_q[6:0], sda};
    end
  end

  // Saturating counts of wake low and wake high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_cnt_q <= 16'h0000;
      hi_cnt_q <= 16'hFFFF;
    end else begin
      lo_cnt_q <= wake_request_n ? 16'h0000 : lo_cnt_q + {15'h0000, lo_cnt_q != 16'hFFFF};
      hi_cnt_q <= !wake_request_n ? 16'h0000 : hi_cnt_q + {15'h0000, hi_cnt_q != 16'hFFFF};
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_asleep;
    wake_request_n [*8];
  endsequence
  sequence s_release;
    ##[1:8] !sda_dev_oe;
  endsequence

  property p_asleep_quiet;
    s_asleep |-> !sda_dev_oe;
  endproperty
  property p_wake_lead;
    start_c |-> lo_cnt_q >= WAKE_LEAD_CYC;
  endproperty
  property p_wake_gap;
    $fell(wake_request_n) |-> hi_cnt_q >= WAKE_REL_CYC;
  endproperty
  property p_wake_hold;
    busy_q && !stop_c |-> !wake_request_n;
  endproperty
  property p_addr_ack;
    slot9 && first_q && !sda |-> shf_q[7:2] == `IMB_ADDR_HI;
  endproperty
  property p_wr_ack;
    slot9 && !first_q && !rw_q && addr_ok_q |-> !sda;
  endproperty
  property p_ack_release;
    scl_fall && ack_q && !rw_q |-> s_release;
  endproperty
  property p_dev_edge;
    $changed(sda_dev_oe) |-> !scl;
  endproperty

  a_asleep_quiet: assert property (p_asleep_quiet)
    else $error("device drives data while not woken");
  a_wake_lead: assert property (p_wake_lead)
    else $error("start too soon after wake");
  a_wake_gap: assert property (p_wake_gap)
    else $error("wake released too briefly");
  a_wake_hold: assert property (p_wake_hold)
    else $error("wake released inside a frame");
  a_addr_ack: assert property (p_addr_ack)
    else $error("foreign address acknowledged");
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge not released");
  a_dev_edge: assert property (p_dev_edge)
    else $error("device changed data while clock high");
endmodule : imb_chk

`default_nettype wire

//--- testbench/tb_top.sv
// Testbench: host and device ends joined by the interface, mailbox model on the device side.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import imb_pkg::*;
  localparam int LEAD = 40;
  localparam int REL  = 20;
  // Short bus quarter keeps the run small; the device only needs a few cycles per phase
  localparam int QTR  = 8;

  logic        i_clk, i_rst_n, i_req, i_req_read, i_req_sel, i_addr_lsb;
  logic        i_bus_id_sel, i_irq_n, wr_take, rd_v, busy, nack, irq;
  logic        sel_v, wr_v, rd_take;
  logic [3:0]  i_req_len;
  logic [7:0]  i_req_reg, wr_byte, rd_byte, wr_reg, wr_data, ptr, rd_data, cur;
  logic [7:0]  mem [256];
  logic [7:0]  exp_sel[$], exp_rd[$], wq[$];
  logic [15:0] exp_wr[$];
  int          n_errors, n_compared, n_take, exp_take;

  imb_if bus_if ();

  imb_host #(.QTR_CYC(QTR), .WAKE_LEAD_CYC(LEAD), .WAKE_REL_CYC(REL)) imb_host_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus_if), .i_req(i_req),
    .i_req_read(i_req_read), .i_req_sel(i_req_sel), .i_req_reg(i_req_reg),
    .i_req_len(i_req_len), .i_addr_lsb(i_addr_lsb), .i_wr_byte(wr_byte),
    .o_wr_take(wr_take), .o_rd_valid(rd_v), .o_rd_byte(rd_byte), .o_busy(busy),
    .o_nack(nack), .o_irq(irq));

  imb_dev imb_dev_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus_if), .i_bus_id_sel(i_bus_id_sel),
    .i_irq_n(i_irq_n), .o_sel_valid(sel_v), .o_wr_valid(wr_v), .o_wr_reg(wr_reg),
    .o_wr_data(wr_data), .o_ptr(ptr), .o_rd_take(rd_take), .i_rd_data(rd_data));

  imb_chk #(.WAKE_LEAD_CYC(LEAD), .WAKE_REL_CYC(REL)) imb_chk_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .scl_host_oe(bus_if.scl_host_oe),
    .sda_host_oe(bus_if.sda_host_oe), .sda_dev_oe(bus_if.sda_dev_oe),
    .wake_request_n(bus_if.wake_request_n), .irq_out_n(bus_if.irq_out_n),
    .scl(bus_if.scl), .sda(bus_if.sda));

  // Mailbox storage answers for the current pointer
  assign rd_data = mem[ptr];

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk16

  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk1

  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Feed write bytes in order, one per take
  always @(posedge i_clk) begin
    if (wr_take === 1'b1 && wq.size() > 0) void'(wq.pop_front());
    #1;
    wr_byte = (wq.size() > 0) ? wq[0] : 8'h00;
  end

  // Compare select, write and read-data pulses with the model queues; only count read takes
  always @(posedge i_clk) begin
    if (sel_v === 1'b1) chk8("sel_ptr", exp_sel.size() ? exp_sel.pop_front() : 8'hXX, ptr);
    if (wr_v === 1'b1) chk16("wr", exp_wr.size() ? exp_wr.pop_front() : 16'hXXXX,
                             {wr_reg, wr_data});
    if (rd_v === 1'b1) chk8("rd_byte", exp_rd.size() ? exp_rd.pop_front() : 8'hXX, rd_byte);
    if (rd_take === 1'b1) n_take++;
  end

  task automatic xfer(input logic rd, input logic sl, input logic [7:0] rg,
                      input logic [3:0] len, input logic lsb);
    int         k;
    logic [7:0] b;
    logic       ok;
    ok = (lsb === i_bus_id_sel);
    if (ok && (!rd || sl)) begin
      exp_sel.push_back(rg);
      cur = rg;
    end
    if (ok && rd) exp_take += len;
    for (k = 0; k < len; k++) begin
      b = 8'($urandom);
      if (!rd) wq.push_back(b);
      if (ok && !rd) exp_wr.push_back({rg, b});
      if (ok && rd) exp_rd.push_back(mem[cur]);
    end
    @(posedge i_clk);
    #1;
    i_req      = 1'b1;
    i_req_read = rd;
    i_req_sel  = sl;
    i_req_reg  = rg;
    i_req_len  = len;
    i_addr_lsb = lsb;
    @(posedge i_clk);
    #1;
    i_req = 1'b0;
    for (k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge i_clk);
    #1;
    chk1("busy_done", 1'b0, busy);
    chk8("pending", 8'h00, 8'(exp_sel.size() + exp_wr.size() + exp_rd.size()));
    chk1("nack", !ok, nack);
    chk8("ptr", cur, ptr);
    chk16("rd_take", 16'(exp_take), 16'(n_take));
    wq.delete();
  endtask : xfer

  initial begin
    repeat (40000) @(posedge i_clk);
    n_errors++;
    $display("BAD watchdog exp done got timeout");
    end_sim();
  end

  initial begin
    byte unsigned base;
    i_rst_n      = 1'b0;
    i_req        = 1'b0;
    i_req_read   = 1'b0;
    i_req_sel    = 1'b0;
    i_req_reg    = 8'h00;
    i_req_len    = 4'h0;
    i_addr_lsb   = 1'b1;
    i_bus_id_sel = 1'b1;
    i_irq_n      = 1'b1;
    wr_byte      = 8'h00;
    cur          = 8'h00;
    n_errors     = 0;
    n_compared   = 0;
    n_take       = 0;
    exp_take     = 0;
    void'($urandom(32'h740b));
    base = 8'($urandom);
    foreach (mem[i]) mem[i] = 8'(i * 37) + base;
    repeat (12) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    repeat (4) @(posedge i_clk);
    chk8("ptr_rst", 8'h00, ptr);
    xfer(1'b0, 1'b0, 8'($urandom), 4'h2, 1'b1);
    xfer(1'b0, 1'b0, 8'($urandom), 4'h0, 1'b1);
    xfer(1'b1, 1'b0, 8'($urandom), 4'h2, 1'b1);
    xfer(1'b1, 1'b0, 8'($urandom), 4'h1, 1'b1);
    i_bus_id_sel = 1'b0;
    repeat (10) @(posedge i_clk);
    xfer(1'b0, 1'b0, 8'($urandom), 4'h1, 1'b0);
    xfer(1'b1, 1'b1, 8'($urandom), 4'h2, 1'b0);
    xfer(1'b0, 1'b0, 8'($urandom), 4'h1, 1'b1);
    i_irq_n = 1'b0;
    repeat (8) @(posedge i_clk);
    chk1("irq_set", 1'b1, irq);
    #1;
    i_irq_n = 1'b1;
    repeat (8) @(posedge i_clk);
    chk1("irq_clr", 1'b0, irq);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire

//--- verilog/imb_cfg.svh
// Constants for the mailbox serial register-access link, both ends.
// Assumes a 250 MHz system clock on both ends and a 100 kHz bus clock from the host.
`ifndef IMB_CFG_SVH
`define IMB_CFG_SVH

// Clock rate and bus rate
`define IMB_CLK_MHZ       250
`define IMB_SCL_KHZ       100
// Quarter of one bus-clock period, in system cycles
`define IMB_QTR_CYC       ((`IMB_CLK_MHZ * 1000) / (`IMB_SCL_KHZ * 4))

// Wake lead time and wake release time, in microseconds and in cycles
`define IMB_WAKE_LEAD_US  50
`define IMB_WAKE_REL_US   20
`define IMB_WAKE_LEAD_CYC (`IMB_WAKE_LEAD_US * `IMB_CLK_MHZ)
`define IMB_WAKE_REL_CYC  (`IMB_WAKE_REL_US * `IMB_CLK_MHZ)

// Upper six bits of the 7-bit slave address; the select pin gives the lsb
`define IMB_ADDR_HI       6'h2D

// Bits per byte, counted before the acknowledge slot
`define IMB_BITS          4'h8

`endif

//--- verilog/imb_dev.sv
// Device end: serial slave that selects a mailbox register and moves bytes to or from it.
// Assumes the mailbox storage sits on the user side and answers i_rd_data for o_ptr.
// Notes on behaviour
// - Host holds wake low before and during transactions.
// - Address lsb follows the bus-id select pin.
// - First written byte is the register address.
// - Pointer never increments within a sequence.
// - Address-only write just moves the pointer.
// - Second written byte stores into selected register.
// - Further written bytes all go, in order.
// - Host selects a register before reading it.
// - Reads work after stop or repeated start.
// - Pointer persists across separate read transactions.
// - Wake held low keeps device always ready.
// - Host services the interrupt output.
// - Answer only to address 0x5A or 0x5B.
// - Wake lead time at least 50 us.
// - Wake released at least 20 us between.
// - Host never overreads a register's size.
`timescale 1ns/1ps
`default_nettype none

`include "imb_cfg.svh"

module imb_dev
  import imb_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Serial bus
  imb_if.dev              bus,
  // Strap and interrupt request
  input  wire logic       i_bus_id_sel,
  input  wire logic       i_irq_n,
  // Mailbox write side
  output logic            o_sel_valid,
  output logic            o_wr_valid,
  output logic [7:0]      o_wr_reg,
  output logic [7:0]      o_wr_data,
  // Mailbox read side
  output logic [7:0]      o_ptr,
  output logic            o_rd_take,
  input  wire logic [7:0] i_rd_data
);

  function automatic logic addr_hit(input logic [6:0] a, input logic lsb);
    addr_hit = (a == {`IMB_ADDR_HI, lsb});
  endfunction : addr_hit

  logic [2:0]     scl_s_q;
  logic [2:0]     sda_s_q;
  logic [1:0]     wake_s_q;
  logic [1:0]     id_s_q;
  logic           id_q;
  imb_dev_state_t st_q;
  logic [3:0]     cnt_q;
  logic [7:0]     sh_q;
  logic           rw_q;
  logic           first_q;
  logic           nack_q;
  logic           sda_oe_q;
  logic           irq_n_q;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_det;
  logic           stop_det;
  logic           wake_on;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s_q  <= '1;
      sda_s_q  <= '1;
      wake_s_q <= '1;
      id_s_q   <= '0;
    end else begin
      scl_s_q  <= {scl_s_q[1:0], bus.scl};
      sda_s_q  <= {sda_s_q[1:0], bus.sda};
      wake_s_q <= {wake_s_q[0], bus.wake_request_n};
      id_s_q   <= {id_s_q[0], i_bus_id_sel};
    end
  end

  assign scl_rise  = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall  = ~scl_s_q[1] & scl_s_q[2];
  assign start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  assign stop_det  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
  assign wake_on   = ~wake_s_q[1];

  // Strap is taken only while no transaction is under way
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      id_q <= 1'b0;
    end else if (st_q == DS_IDLE) begin
      id_q <= id_s_q[1];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= i_irq_n;
    end
  end

  // Protocol engine
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q        <= DS_IDLE;
      cnt_q       <= '0;
      sh_q        <= '0;
      rw_q        <= 1'b0;
      first_q     <= 1'b0;
      nack_q      <= 1'b0;
      sda_oe_q    <= 1'b0;
      o_ptr       <= '0;
      o_sel_valid <= 1'b0;
      o_wr_valid  <= 1'b0;
      o_wr_reg    <= '0;
      o_wr_data   <= '0;
      o_rd_take   <= 1'b0;
    end else begin
      o_sel_valid <= 1'b0;
      o_wr_valid  <= 1'b0;
      o_rd_take   <= 1'b0;
      if (stop_det) begin
        st_q     <= DS_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start_det) begin
        // A repeated start lands here too; the pointer is kept
        st_q     <= DS_ADDR;
        cnt_q    <= '0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          DS_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          DS_ADDR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s_q[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `IMB_BITS) begin
              if (addr_hit(sh_q[7:1], id_q) && wake_on) begin
                st_q     <= DS_AACK;
                sda_oe_q <= 1'b1;
                rw_q     <= sh_q[0];
                first_q  <= ~sh_q[0];
              end else begin
                st_q <= DS_IDLE;
              end
            end
          end
          DS_AACK: begin
            if (scl_fall) begin
              cnt_q <= '0;
              if (rw_q) begin
                // Read returns the register chosen earlier
                st_q      <= DS_TX;
                sh_q      <= i_rd_data;
                sda_oe_q  <= ~i_rd_data[7];
                o_rd_take <= 1'b1;
              end else begin
                st_q     <= DS_RX;
                sda_oe_q <= 1'b0;
              end
            end
          end
          DS_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s_q[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `IMB_BITS) begin
              st_q     <= DS_RACK;
              sda_oe_q <= 1'b1;
              if (first_q) begin
                o_ptr       <= sh_q;
                o_sel_valid <= 1'b1;
                first_q     <= 1'b0;
              end else begin
                o_wr_valid <= 1'b1;
                o_wr_reg   <= o_ptr;
                o_wr_data  <= sh_q;
              end
            end
          end
          DS_RACK: begin
            if (scl_fall) begin
              st_q     <= DS_RX;
              sda_oe_q <= 1'b0;
              cnt_q    <= '0;
            end
          end
          DS_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == `IMB_BITS) begin
                st_q     <= DS_TACK;
                sda_oe_q <= 1'b0;
              end else begin
                sh_q     <= {sh_q[6:0], 1'b0};
                sda_oe_q <= ~sh_q[6];
              end
            end
          end
          DS_TACK: begin
            if (scl_rise) begin
              nack_q <= sda_s_q[1];
            end else if (scl_fall) begin
              cnt_q <= '0;
              if (!nack_q) begin
                // Same mailbox again, no increment
                st_q      <= DS_TX;
                sh_q      <= i_rd_data;
                sda_oe_q  <= ~i_rd_data[7];
                o_rd_take <= 1'b1;
              end else begin
                st_q <= DS_IDLE;
              end
            end
          end
          default: begin
            st_q     <= DS_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign bus.sda_dev_oe = sda_oe_q;
  assign bus.irq_out_n  = irq_n_q;

endmodule : imb_dev

`default_nettype wire

//--- verilog/imb_host.sv
// Host end: bus master that wakes the device, selects a mailbox and moves bytes.
// Assumes no clock stretching by the device and one request at a time.
`timescale 1ns/1ps
`default_nettype none

`include "imb_cfg.svh"

module imb_host
  import imb_pkg::*;
#(
  parameter int unsigned QTR_CYC       = `IMB_QTR_CYC,
  parameter int unsigned WAKE_LEAD_CYC = `IMB_WAKE_LEAD_CYC,
  parameter int unsigned WAKE_REL_CYC  = `IMB_WAKE_REL_CYC
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Serial bus
  imb_if.host             bus,
  // Request
  input  wire logic       i_req,
  input  wire logic       i_req_read,
  input  wire logic       i_req_sel,
  input  wire logic [7:0] i_req_reg,
  input  wire logic [3:0] i_req_len,
  input  wire logic       i_addr_lsb,
  // Write data
  input  wire logic [7:0] i_wr_byte,
  output logic            o_wr_take,
  // Read data
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_byte,
  // Status
  output logic            o_busy,
  output logic            o_nack,
  output logic            o_irq
);

  localparam logic [15:0] QTR_M1  = 16'(QTR_CYC - 1);
  localparam logic [15:0] LEAD_M1 = 16'(WAKE_LEAD_CYC - 1);
  localparam logic [15:0] REL_M1  = 16'(WAKE_REL_CYC - 1);

  imb_host_state_t st_q;
  imb_stage_t      stage_q;
  logic [15:0]     tmr_q;
  logic [1:0]      ph_q;
  logic [3:0]      bit_q;
  logic [7:0]      sh_q;
  logic [7:0]      reg_q;
  logic [3:0]      left_q;
  logic            read_q;
  logic            rdp_q;
  logic            lsb_q;
  logic            scl_oe_q;
  logic            sda_oe_q;
  logic            wake_n_q;
  logic [1:0]      sda_s_q;
  logic [1:0]      irq_s_q;
  logic            tick;
  logic            rx;
  logic            last;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_s_q <= '1;
      irq_s_q <= '1;
      o_irq   <= 1'b0;
    end else begin
      sda_s_q <= {sda_s_q[0], bus.sda};
      irq_s_q <= {irq_s_q[0], bus.irq_out_n};
      o_irq   <= ~irq_s_q[1];
    end
  end

  assign tick = (tmr_q == '0);
  assign rx   = (stage_q == STG_DATA) && rdp_q;
  assign last = (left_q == 4'h1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q       <= HS_IDLE;
      stage_q    <= STG_ADDR;
      tmr_q      <= '0;
      ph_q       <= '0;
      bit_q      <= '0;
      sh_q       <= '0;
      reg_q      <= '0;
      left_q     <= '0;
      read_q     <= 1'b0;
      rdp_q      <= 1'b0;
      lsb_q      <= 1'b0;
      scl_oe_q   <= 1'b0;
      sda_oe_q   <= 1'b0;
      wake_n_q   <= 1'b1;
      o_wr_take  <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_byte  <= '0;
      o_busy     <= 1'b0;
      o_nack     <= 1'b0;
    end else begin
      o_wr_take  <= 1'b0;
      o_rd_valid <= 1'b0;
      if (!tick) begin
        tmr_q <= tmr_q - 16'h1;
      end
      unique case (st_q)
        HS_IDLE: begin
          if (i_req) begin
            st_q     <= HS_WAKE;
            wake_n_q <= 1'b0;
            tmr_q    <= LEAD_M1;
            o_busy   <= 1'b1;
            o_nack   <= 1'b0;
            read_q   <= i_req_read;
            rdp_q    <= i_req_read & ~i_req_sel;
            reg_q    <= i_req_reg;
            left_q   <= i_req_len;
            lsb_q    <= i_addr_lsb;
          end
        end
        HS_WAKE: begin
          if (tick) begin
            st_q  <= HS_START;
            ph_q  <= '0;
            tmr_q <= QTR_M1;
          end
        end
        HS_START: begin
          if (tick) begin
            tmr_q <= QTR_M1;
            ph_q  <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              2'h3: begin
                scl_oe_q <= 1'b1;
                st_q     <= HS_BITS;
                bit_q    <= '0;
                stage_q  <= STG_ADDR;
                sh_q     <= {`IMB_ADDR_HI, lsb_q, rdp_q};
              end
            endcase
          end
        end
        HS_BITS: begin
          if (tick) begin
            tmr_q <= QTR_M1;
            ph_q  <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: begin
                if (bit_q != `IMB_BITS) begin
                  sda_oe_q <= ~rx & ~sh_q[7];
                end else begin
                  sda_oe_q <= rx & ~last;
                end
              end
              2'h1: scl_oe_q <= 1'b0;
              2'h2: begin
                if (bit_q != `IMB_BITS) begin
                  sh_q <= {sh_q[6:0], sda_s_q[1]};
                end else if (!rx && sda_s_q[1]) begin
                  o_nack <= 1'b1;
                end
              end
              2'h3: begin
                scl_oe_q <= 1'b1;
                bit_q    <= bit_q + 4'h1;
                if (bit_q == `IMB_BITS) begin
                  bit_q <= '0;
                  if (o_nack) begin
                    st_q <= HS_STOP;
                  end else begin
                    unique case (stage_q)
                      STG_ADDR: begin
                        if (rdp_q) begin
                          stage_q <= STG_DATA;
                        end else begin
                          stage_q <= STG_REG;
                          sh_q    <= reg_q;
                        end
                      end
                      STG_REG: begin
                        if (read_q) begin
                          st_q  <= HS_START;
                          rdp_q <= 1'b1;
                        end else if (left_q == '0) begin
                          st_q <= HS_STOP;
                        end else begin
                          stage_q   <= STG_DATA;
                          sh_q      <= i_wr_byte;
                          o_wr_take <= 1'b1;
                        end
                      end
                      default: begin
                        if (rdp_q) begin
                          o_rd_valid <= 1'b1;
                          o_rd_byte  <= sh_q;
                        end
                        left_q <= left_q - 4'h1;
                        if (last) begin
                          st_q <= HS_STOP;
                        end else if (!rdp_q) begin
                          sh_q      <= i_wr_byte;
                          o_wr_take <= 1'b1;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            tmr_q <= QTR_M1;
            ph_q  <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              2'h3: begin
                st_q     <= HS_GAP;
                wake_n_q <= 1'b1;
                tmr_q    <= REL_M1;
              end
            endcase
          end
        end
        HS_GAP: begin
          if (tick) begin
            st_q   <= HS_IDLE;
            o_busy <= 1'b0;
          end
        end
        default: begin
          st_q     <= HS_IDLE;
          scl_oe_q <= 1'b0;
          sda_oe_q <= 1'b0;
          wake_n_q <= 1'b1;
          o_busy   <= 1'b0;
        end
      endcase
    end
  end

  assign bus.scl_host_oe    = scl_oe_q;
  assign bus.sda_host_oe    = sda_oe_q;
  assign bus.wake_request_n = wake_n_q;

endmodule : imb_host

`default_nettype wire

//--- verilog/imb_if.sv
// Open-drain serial bus between host and device, with wake and interrupt wires.
// Assumes pull-ups: a line reads high unless some end enables its low drive.
`timescale 1ns/1ps
`default_nettype none

interface imb_if;
  logic scl_host_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic wake_request_n;
  logic irq_out_n;
  logic scl;
  logic sda;

  // Wired-AND of the open-drain drivers
  assign scl = ~scl_host_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport host (
    output scl_host_oe,
    output sda_host_oe,
    output wake_request_n,
    input  scl,
    input  sda,
    input  irq_out_n
  );

  modport dev (
    output sda_dev_oe,
    output irq_out_n,
    input  scl,
    input  sda,
    input  wake_request_n
  );
endinterface : imb_if

`default_nettype wire

//--- verilog/imb_pkg.sv
// Types shared by the two ends of the mailbox link.
// Assumes imb_cfg.svh supplies the numeric constants.
`default_nettype none

package imb_pkg;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_ADDR = 3'h1,
    DS_AACK = 3'h3,
    DS_RX   = 3'h2,
    DS_RACK = 3'h6,
    DS_TX   = 3'h7,
    DS_TACK = 3'h5
  } imb_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'h0,
    HS_WAKE  = 3'h1,
    HS_START = 3'h3,
    HS_BITS  = 3'h2,
    HS_STOP  = 3'h6,
    HS_GAP   = 3'h4
  } imb_host_state_t;

  typedef enum logic [1:0] {
    STG_ADDR = 2'h0,
    STG_REG  = 2'h1,
    STG_DATA = 2'h3
  } imb_stage_t;

endpackage : imb_pkg

`default_nettype wire
